// File: common/pfc_map.svh
// register map, field positions, reset values and arithmetic constants of the fir configuration block
`ifndef PFC_MAP_SVH
`define PFC_MAP_SVH
// register indices; the byte address is four times the index
`define PFC_IDX_CFG 14'h400
`define PFC_IDX_STAT 14'h402
`define PFC_IDX_COEF_A 14'h418
`define PFC_IDX_COEF_B 14'h430
`define PFC_COEF_STRIDE 2
// configuration field positions
`define PFC_MODE_LSB 0
`define PFC_MODE_MSB 1
`define PFC_SCW_LSB 2
`define PFC_SCW_MSB 4
`define PFC_MERGE_BIT 5
`define PFC_SHARE_BIT 6
// values
`define PFC_CFG_RESET 8'h00
`define PFC_MODE_ENABLE 2'h2
`define PFC_SCW_MAX 3'h6
`define PFC_CTR_SHIFT 5
`define PFC_FRAC_BITS 16
`define PFC_SAMPLE_MAX 16'sh07ff
`define PFC_SAMPLE_MIN 16'shf800
`endif

// File: common/pfc_pkg.sv
// types shared by the fir configuration block and its users
package pfc_pkg;
	typedef logic signed [11:0] pfc_sample_t;
	typedef logic signed [11:0] pfc_coef_t;
	// one beat of the two converter channels, a first in time
	typedef struct packed {
		pfc_sample_t a;
		pfc_sample_t b;
	} pfc_pair_t;
	// apb request as seen by the slave
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [15:0] addr;
		logic [31:0] wdata;
	} pfc_apb_req_t;
endpackage

// File: src/pfc_filter.sv
// programmable fir equalizer: apb configuration, coefficient store, two-channel filter and output buffer
//
// Overview of operation
// (RULE1) With the sharing bit set, filter B runs on the coefficients programmed for filter A.
// (RULE2) With the sharing bit clear, filter B runs on its own coefficient set, independent of A; the code runs it on the A set while the merge bit is set.
// (RULE3) With the merge bit set, both filters act as one filter over the interleaved sample stream.
// (RULE4) Software sets the merge bit whenever the converter runs in single-channel mode.
// (RULE5) The side-weight field scales every coefficient except the centre one, which keeps a fixed weight.
// (RULE6) The side-coefficient lsb weighs two to the power of the field minus 16, for field values 0 to 6.
// (RULE7) With the field at its reset value of zero the side lsb weighs two to the minus sixteen.
// (RULE8) Each step up in side weight doubles the coefficient range and halves its precision.
// (RULE9) After reset the configuration register reads zero and the filter is disabled.
// (RULE10) Mode 0 disables the filter, mode 2 enables it, and modes 1 and 3 are reserved.
// (RULE11) Software changes configuration and coefficients only while the output link is disabled.
// (RULE12) Coefficients are 12-bit signed values, and tap 0 of filter A is also tap 0 of the merged filter.
// (RULE13) Software that enables the filter also programs its coefficients.
// (RULE14) Software writes zero to the reserved top configuration bit and ignores its read value.
`timescale 1ns/1ps
`include "pfc_map.svh"
module pfc_filter #(
	parameter int NTAPS = 5,
	parameter int CTR = 2
) (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [15:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire pfc_pkg::pfc_pair_t IN_DATA,
	input wire logic IN_VALID,
	output logic IN_READY,
	output pfc_pkg::pfc_pair_t OUT_DATA,
	output logic OUT_VALID,
	input wire logic OUT_READY
);
	import pfc_pkg::*;

	typedef struct packed {
		logic [7:0] cfg;
		logic [NTAPS-1:0][11:0] coef_a;
		logic [NTAPS-1:0][11:0] coef_b;
		logic [NTAPS-1:0][11:0] hist_a;
		logic [NTAPS-1:0][11:0] hist_b;
		logic [1:0][23:0] fifo;
		logic [1:0] count;
		logic [31:0] rdata;
	} pfc_state_t;

	pfc_state_t st;
	pfc_state_t next_st;
	// a side tap for the weight checks, whichever index the centre takes
	localparam int SIDE = (CTR == 0) ? 1 : 0;

	logic [13:0] widx;
	logic aligned;
	logic hit_cfg;
	logic hit_stat;
	logic [NTAPS-1:0] hit_a;
	logic [NTAPS-1:0] hit_b;
	logic mapped;
	logic wr_access;
	logic rd_setup;
	logic push;
	logic pop;
	logic active;
	logic merge;
	logic share;
	logic [2:0] scw;
	logic [NTAPS-1:0][11:0] nh_a;
	logic [NTAPS-1:0][11:0] nh_b;
	logic [NTAPS-1:0][11:0] src_a;
	logic [NTAPS-1:0][11:0] src_b;
	logic [NTAPS-1:0][11:0] eff_b;
	logic signed [31:0] term_a [NTAPS];
	logic signed [31:0] term_b [NTAPS];
	logic signed [31:0] prod_a [NTAPS];
	logic signed [31:0] prod_b [NTAPS];
	logic signed [31:0] acc_a;
	logic signed [31:0] acc_b;
	logic signed [15:0] res_a;
	logic signed [15:0] res_b;
	pfc_pair_t filt;
	pfc_pair_t push_word;
	logic [31:0] rd_mux;

	// register layout, byte address = four times the index:
	//   cfg    index 0x400  bits 1:0 mode, 4:2 side weight, 5 merge, 6 share, 7 spare read/write
	//   status index 0x402  bit 0 filter active, bits 2:1 buffer fill, bit 3 merge, read only
	//   coef a index 0x418 + 2k, 12-bit signed tap k in bits 11:0, upper bits read zero
	//   coef b index 0x430 + 2k, same layout, used only while sharing and merging are both off
	//   any other index or a misaligned address answers with pslverr and changes nothing
	//   mode codes 1 and 3 are reserved and behave as disabled, so a stray write cannot start the filter
	//   fields are meant to change only while the output link is down; a live change garbles a beat
	// address decode: one aligned word per register index
	assign widx = PADDR[15:2];
	assign aligned = (PADDR[1:0] == 2'h0);
	assign hit_cfg = aligned && (widx == `PFC_IDX_CFG);
	assign hit_stat = aligned && (widx == `PFC_IDX_STAT);
	genvar g;
	generate
		for (g = 0; g < NTAPS; g++) begin : g_dec
			assign hit_a[g] = aligned && (widx == 14'(`PFC_IDX_COEF_A + `PFC_COEF_STRIDE * g));
			assign hit_b[g] = aligned && (widx == 14'(`PFC_IDX_COEF_B + `PFC_COEF_STRIDE * g));
		end
	endgenerate
	assign mapped = hit_cfg || hit_stat || (|hit_a) || (|hit_b);

	// zero-wait slave; read data is captured in the setup cycle so prdata comes from a flop
	// an unmapped or misaligned access still completes, flagged by pslverr, and changes nothing
	assign PREADY = PSEL && PENABLE;
	assign PSLVERR = PSEL && PENABLE && !mapped;
	assign PRDATA = st.rdata;
	assign wr_access = PSEL && PENABLE && PWRITE && mapped;
	assign rd_setup = PSEL && !PENABLE && !PWRITE;

	// configuration fields; mode values other than enable are treated as disabled
	assign active = (st.cfg[`PFC_MODE_MSB:`PFC_MODE_LSB] == `PFC_MODE_ENABLE); // [RULE10]
	assign merge = st.cfg[`PFC_MERGE_BIT];
	assign share = st.cfg[`PFC_SHARE_BIT];
	// reserved weight 7 is clamped to the largest legal value rather than overflowing the term
	assign scw = (st.cfg[`PFC_SCW_MSB:`PFC_SCW_LSB] > `PFC_SCW_MAX) ? `PFC_SCW_MAX : st.cfg[`PFC_SCW_MSB:`PFC_SCW_LSB];

	// stream handshakes; the two-entry buffer refuses input only when both entries hold words
	// one beat a cycle at most; a pop in the same cycle does not reopen a full buffer
	assign IN_READY = (st.count != 2'h2);
	assign push = IN_VALID && IN_READY;
	assign OUT_VALID = (st.count != 2'h0);
	assign pop = OUT_VALID && OUT_READY;
	assign OUT_DATA = st.fifo[0];

	// read multiplexer
	// the map has no overlapping indices, so the order of the hits below does not matter
	always_comb begin
		rd_mux = 32'h0;
		if (hit_cfg) begin
			rd_mux = {24'h0, st.cfg};
		end
		if (hit_stat) begin
			rd_mux = {28'h0, merge, st.count, active};
		end
		for (int k = 0; k < NTAPS; k++) begin
			if (hit_a[k]) begin
				rd_mux = {20'h0, st.coef_a[k]};
			end
			if (hit_b[k]) begin
				rd_mux = {20'h0, st.coef_b[k]};
			end
		end
	end

	// the sum sits on a 2^-16 grid; dropping the 16 fraction bits leaves the sample in 12-bit units
	// trade-off: the whole sum is one combinational path, bought for a one-cycle latency that is easy to check
	// coefficients only change while the link is down, so no care is taken for a mid-beat update
	// filter arithmetic on the history that includes the beat being accepted
	always_comb begin
		nh_a = {st.hist_a[NTAPS-2:0], IN_DATA.a};
		nh_b = {st.hist_b[NTAPS-2:0], IN_DATA.b};
		acc_a = 32'sh0;
		acc_b = 32'sh0;
		for (int k = 0; k < NTAPS; k++) begin
			if (merge) begin
				// one stream a0 b0 a1 b1 ...: neighbours of an a sample are b samples and the reverse
				if (k % 2 == 0) begin
					src_a[k] = nh_a[k/2]; // [RULE3]
					src_b[k] = nh_b[k/2];
				end else begin
					src_a[k] = nh_b[(k+1)/2];
					src_b[k] = nh_a[(k-1)/2]; // [RULE3]
				end
			end else begin
				src_a[k] = nh_a[k];
				src_b[k] = nh_b[k];
			end
			// merged filter is one logical filter, so it always runs on the a set with tap 0 first
			eff_b[k] = (share || merge) ? st.coef_a[k] : st.coef_b[k]; // [RULE1] [RULE2] [RULE12]
			// widen before multiplying: a 12 by 12 product needs 24 bits, the weight shift up to 6 more
			prod_a[k] = 32'($signed(src_a[k])) * 32'($signed(st.coef_a[k]));
			prod_b[k] = 32'($signed(src_b[k])) * 32'($signed(eff_b[k]));
			// centre tap has a fixed 2^-11 lsb, side taps 2^(scw-16), all on a 2^-16 grid
			if (k == CTR) begin
				term_a[k] = prod_a[k] <<< `PFC_CTR_SHIFT; // [RULE5]
				term_b[k] = prod_b[k] <<< `PFC_CTR_SHIFT;
			end else begin
				term_a[k] = prod_a[k] <<< scw; // [RULE6] [RULE7] [RULE8]
				term_b[k] = prod_b[k] <<< scw;
			end
			acc_a = acc_a + term_a[k];
			acc_b = acc_b + term_b[k];
		end
		res_a = 16'(acc_a >>> `PFC_FRAC_BITS);
		res_b = 16'(acc_b >>> `PFC_FRAC_BITS);
		// saturate rather than wrap so a hot coefficient set clips instead of flipping sign
		if (res_a > `PFC_SAMPLE_MAX) begin
			filt.a = 12'sh7ff;
		end else if (res_a < `PFC_SAMPLE_MIN) begin
			filt.a = 12'sh800;
		end else begin
			filt.a = res_a[11:0];
		end
		if (res_b > `PFC_SAMPLE_MAX) begin
			filt.b = 12'sh7ff;
		end else if (res_b < `PFC_SAMPLE_MIN) begin
			filt.b = 12'sh800;
		end else begin
			filt.b = res_b[11:0];
		end
		push_word = active ? filt : IN_DATA; // [RULE10]
	end

	// next state: registers, history and the output buffer
	always_comb begin
		next_st = st;
		if (rd_setup) begin
			next_st.rdata = rd_mux;
		end
		// writes land only in the access phase, so a setup cycle alone never commits
		if (wr_access && hit_cfg) begin
			next_st.cfg = PWDATA[7:0];
		end
		// coefficient writes keep only the low 12 bits; the upper bits read back as zero
		for (int k = 0; k < NTAPS; k++) begin
			if (wr_access && hit_a[k]) begin
				next_st.coef_a[k] = PWDATA[11:0]; // [RULE12]
			end
			if (wr_access && hit_b[k]) begin
				next_st.coef_b[k] = PWDATA[11:0]; // [RULE2]
			end
		end
		// history moves on every accepted beat, bypassed or not, so enabling starts on real samples
		if (push) begin
			next_st.hist_a = nh_a;
			next_st.hist_b = nh_b;
		end
		// pop shifts the head out first, then a push lands behind what remains
		if (pop) begin
			next_st.fifo[0] = st.fifo[1];
			next_st.count = st.count - 2'h1;
		end
		if (push) begin
			next_st.fifo[next_st.count[0]] = push_word;
			next_st.count = next_st.count + 2'h1;
		end
	end

	// state register with synchronous reset
	// everything clears to zero; the configuration value is named so that it can be changed alone
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			st <= '0;
			st.cfg <= `PFC_CFG_RESET; // [RULE9]
		end else begin
			st <= next_st;
		end
	end

	// checks on the design's own behaviour
	// all checks sample at the rising edge and stand down while reset is low
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N);

	a_share_coef_use: assert property (share |-> eff_b == st.coef_a) // [RULE1]
		else $error("filter b not on a coefficients while sharing");
	a_own_coef_use: assert property (!share && !merge |-> eff_b == st.coef_b) // [RULE2]
		else $error("filter b not on its own coefficients");
	a_merge_stream_order: assert property (merge && push |-> src_b[1] == IN_DATA.a && src_a[1] == st.hist_b[0]) // [RULE3]
		else $error("merged stream not interleaved");
	a_centre_fixed_weight: assert property (push |-> term_a[CTR] // [RULE5]
		== 32'($signed(src_a[CTR])) * 32'($signed(st.coef_a[CTR])) * 32)
		else $error("centre tap weight depends on side weight");
	a_side_lsb_weight: assert property (push && scw == 3'h3 |-> term_a[SIDE] // [RULE6]
		== 32'($signed(src_a[SIDE])) * 32'($signed(st.coef_a[SIDE])) * 8)
		else $error("side tap weight wrong");
	a_reset_config_zero: assert property ($rose(RESET_N) |-> st.cfg == 8'h00 && !active && scw == 3'h0) // [RULE9]
		else $error("configuration not zero after reset");
	a_mode_bypass_word: assert property (push && !active && st.count == 2'h0 && !pop
		|=> OUT_VALID && OUT_DATA == $past(IN_DATA)) // [RULE10]
		else $error("disabled filter altered the sample");
	a_coef_write_store: assert property (wr_access && hit_a[0] |=> st.coef_a[0] == $past(PWDATA[11:0])) // [RULE12]
		else $error("tap 0 write not stored");
	a_buffer_hold: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA))
		else $error("buffered word lost under stall");
	a_unmapped_error: assert property (PSEL && PENABLE && !mapped |-> PSLVERR && PREADY)
		else $error("unmapped access not flagged");

	// side taps at the reset weight sit one for one on the 2^-16 grid
	a_side_zero_weight: assert property (push && scw == 3'h0 |-> term_a[SIDE] // [RULE7]
		== 32'($signed(src_a[SIDE])) * 32'($signed(st.coef_a[SIDE])))
		else $error("side tap weight at zero setting wrong");
	// the largest legal weight scales side taps by 2^6, widening range and coarsening steps
	a_side_max_weight: assert property (push && scw == 3'h6 |-> term_a[SIDE] // [RULE8]
		== 32'($signed(src_a[SIDE])) * 32'($signed(st.coef_a[SIDE])) * 64)
		else $error("side tap weight at largest setting wrong");
	// the reserved weight code is held at the largest legal one
	a_weight_clamp: assert property (st.cfg[`PFC_SCW_MSB:`PFC_SCW_LSB] == 3'h7 |-> scw == `PFC_SCW_MAX) // [RULE6]
		else $error("reserved side weight not clamped");
	// the merged filter is one logical filter and runs on the a set only
	a_merge_a_coefs: assert property (merge |-> eff_b == st.coef_a) // [RULE3] [RULE12]
		else $error("merged filter not on a coefficients");
	// an enabled filter queues the filtered word, not the raw one
	a_enabled_filters_word: assert property (push && active && st.count == 2'h0 && !pop // [RULE10]
		|=> OUT_VALID && OUT_DATA == $past(filt))
		else $error("enabled filter did not queue the filtered word");

	// register writes and reads
	a_cfg_write_store: assert property (wr_access && hit_cfg |=> st.cfg == $past(PWDATA[7:0]))
		else $error("configuration write not stored");
	a_coef_b_store: assert property (wr_access && hit_b[0] |=> st.coef_b[0] == $past(PWDATA[11:0])) // [RULE2]
		else $error("tap 0 write of set b not stored");
	a_bad_write_ignored: assert property (PSEL && PENABLE && PWRITE && !mapped |=> $stable(st.cfg))
		else $error("unmapped write changed configuration");
	a_bad_read_zero: assert property (PSEL && PENABLE && !PWRITE && !mapped |-> PRDATA == 32'h0)
		else $error("unmapped read returned data");
	// read data is the word selected in the setup cycle
	a_read_data_latch: assert property (PSEL && PENABLE && !PWRITE |-> PRDATA == $past(rd_mux))
		else $error("read data not taken at setup");
	// after reset the outputs are quiet and read data is zero
	a_reset_outputs: assert property ($rose(RESET_N) |-> !OUT_VALID && PRDATA == 32'h0 && IN_READY) // [RULE9]
		else $error("outputs not idle after reset");

	// buffer and history
	a_full_refuse_input: assert property (st.count == 2'h2 |-> !IN_READY && !push)
		else $error("full buffer accepted a word");
	a_count_range: assert property (st.count != 2'h3)
		else $error("buffer fill out of range");
	a_buffer_order: assert property (pop && st.count == 2'h2 |=> OUT_DATA == $past(st.fifo[1]))
		else $error("buffer order broken");
	a_hist_shift: assert property (push |=> st.hist_a[0] == $past(IN_DATA.a) && st.hist_b[0] == $past(IN_DATA.b))
		else $error("history did not take the beat");
	a_hist_hold: assert property (!push |=> $stable(st.hist_a) && $stable(st.hist_b))
		else $error("history moved without a beat");

	c_merged_enabled: cover property (active && merge && push);
	c_shared_enabled: cover property (active && share && !merge && push);
	c_buffer_full_stall: cover property (st.count == 2'h2 && IN_VALID && !OUT_READY);
	c_max_side_weight: cover property (active && scw == 3'h6 && push);
	c_reserved_bypass: cover property (st.cfg[`PFC_MODE_MSB:`PFC_MODE_LSB] == 2'h1 && push);
endmodule

// File: verification/pfc_sink_model.sv
// stream sink standing in for the serial link side: takes output pairs and stalls on command
`timescale 1ns/1ps
module pfc_sink_model (
	input wire logic MCLK,
	input wire logic stall,
	input wire pfc_pkg::pfc_pair_t OUT_DATA,
	input wire logic OUT_VALID,
	output logic OUT_READY
);
	import pfc_pkg::*;
	pfc_pair_t got[$];
	initial OUT_READY = 1'b0;
	// a pair is taken only at an edge where both sides agree; ready lags stall by one cycle, like a real link
	always @(posedge MCLK) begin
		if (OUT_VALID && OUT_READY) got.push_back(OUT_DATA);
		OUT_READY <= !stall;
	end
endmodule

// File: verification/pfc_filter_tb.sv
// self-checking bench for the fir block: registers, weighting, sharing, merging, buffering, bypass
`timescale 1ns/1ps
module pfc_filter_tb;
	import pfc_pkg::*;
	localparam int NT = 5;
	localparam int CT = 2;
	logic MCLK = 1'b0;
	logic RESET_N = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [15:0] PADDR = 16'h0000;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	pfc_pair_t IN_DATA = '0;
	logic IN_VALID = 1'b0;
	logic IN_READY;
	pfc_pair_t OUT_DATA;
	logic OUT_VALID;
	logic OUT_READY;
	logic stall = 1'b0;
	int err_total = 0;
	int num_checks = 0;
	int ca[NT] = '{256, 64, 256, -128, 512};
	int cb[NT] = '{512, -256, 1024, 128, 0};
	logic [31:0] rd;
	logic er;
	int i;
	int j;
	pfc_filter #(.NTAPS(NT), .CTR(CT)) u_pfc_filter (.MCLK(MCLK), .RESET_N(RESET_N), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .IN_DATA(IN_DATA), .IN_VALID(IN_VALID), .IN_READY(IN_READY), .OUT_DATA(OUT_DATA),
		.OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY));
	pfc_sink_model u_pfc_sink_model (.MCLK(MCLK), .stall(stall), .OUT_DATA(OUT_DATA), .OUT_VALID(OUT_VALID),
		.OUT_READY(OUT_READY));
	always #5 MCLK = ~MCLK;
	task automatic results();
		if (err_total == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one apb transfer; the request is held until pready is seen at an edge, then released
	task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [31:0] ex,
		input logic exerr);
		int n;
		n = 0;
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge MCLK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge MCLK);
		if (!w) chk("read data", rd, ex);
		chk("slave error", {31'h0, er}, {31'h0, exerr});
	endtask
	// offers a beat and holds it until accepted; valid stays up for a following beat
	task automatic send(input pfc_pair_t p);
		int n;
		logic ok;
		n = 0;
		IN_DATA <= p;
		IN_VALID <= 1'b1;
		do begin
			@(negedge MCLK);
			ok = IN_READY;
			@(posedge MCLK);
			n++;
		end while (ok !== 1'b1 && n < 50);
	endtask
	task automatic drain(input int cnt);
		int n;
		n = 0;
		while (u_pfc_sink_model.got.size() < cnt && n < 50) begin
			@(posedge MCLK);
			n++;
		end
		chk("pairs out", u_pfc_sink_model.got.size(), cnt);
	endtask
	// expected filter output for an impulse v meeting coefficient tap tp at side weight s
	function automatic logic signed [11:0] f(input int v, input int tp, input int s, input bit useb);
		longint p;
		int c;
		c = (tp >= NT) ? 0 : (useb ? cb[tp] : ca[tp]);
		p = (longint'(v) * c * (longint'(1) <<< ((tp == CT) ? 5 : s))) >>> 16;
		if (p > 2047) p = 2047;
		if (p < -2048) p = -2048;
		return 12'(p);
	endfunction
	// impulse then zeros, with the sink stalled so the two-entry buffer fills and refuses
	task automatic run(input logic [2:0] s, input logic mg, input logic sh, input int va, input int vb);
		pfc_pair_t p;
		int t;
		acc(1'b1, 16'h1000, {25'h0, sh, mg, s, 2'b10}, 32'h0, 1'b0);
		stall <= 1'b1;
		send({12'(va), 12'(vb)});
		send('0);
		IN_VALID <= 1'b0;
		@(negedge MCLK);
		chk("in ready when full", {31'h0, IN_READY}, 32'h0);
		@(posedge MCLK);
		stall <= 1'b0;
		repeat (3) send('0);
		IN_VALID <= 1'b0;
		drain(5);
		for (t = 0; t < 5; t++) begin
			p = u_pfc_sink_model.got.pop_front();
			chk("out a", p.a, f(va, mg ? 2 * t : t, s, 1'b0));
			chk("out b", p.b, mg ? f(va, 2 * t + 1, s, 1'b0) : f(vb, t, s, !sh));
		end
	endtask
	// disabled and reserved modes pass samples through whatever the weight
	task automatic byp(input logic [1:0] m);
		pfc_pair_t p;
		acc(1'b1, 16'h1000, {27'h0, 3'h6, m}, 32'h0, 1'b0);
		send({12'h123, 12'h9ab});
		IN_VALID <= 1'b0;
		drain(1);
		p = u_pfc_sink_model.got.pop_front();
		chk("bypass", {8'h0, p}, {8'h0, 12'h123, 12'h9ab});
	endtask
	initial begin
		repeat (5) @(posedge MCLK);
		RESET_N <= 1'b1;
		repeat (2) @(posedge MCLK);
		acc(1'b0, 16'h1000, 32'h0, 32'h0, 1'b0);
		acc(1'b0, 16'h1008, 32'h0, 32'h0, 1'b0);
		acc(1'b1, 16'h1000, 32'hffffff7f, 32'h0, 1'b0);
		acc(1'b0, 16'h1000, 32'h0, 32'h7f, 1'b0);
		acc(1'b1, 16'h1001, 32'h0, 32'h0, 1'b1);
		acc(1'b0, 16'h1004, 32'h0, 32'h0, 1'b1);
		acc(1'b0, 16'h1000, 32'h0, 32'h7f, 1'b0);
		acc(1'b0, 16'h1008, 32'h0, 32'h8, 1'b0);
		for (i = 0; i < NT; i++) begin
			for (j = 0; j < 2; j++) begin
				acc(1'b1, (j ? 16'h10c0 : 16'h1060) + 16'(8 * i), {20'hfffff, 12'(j ? cb[i] : ca[i])}, 32'h0, 1'b0);
				acc(1'b0, (j ? 16'h10c0 : 16'h1060) + 16'(8 * i), 32'h0, {20'h0, 12'(j ? cb[i] : ca[i])}, 1'b0);
			end
		end
		run(3'h0, 1'b0, 1'b0, 256, 256);
		run(3'h6, 1'b0, 1'b0, 256, 256);
		run(3'h3, 1'b0, 1'b1, 256, -256);
		run(3'h6, 1'b0, 1'b1, 2047, -2048);
		run(3'h2, 1'b1, 1'b0, 256, 0);
		byp(2'h0);
		byp(2'h1);
		byp(2'h3);
		results();
	end
	// a hang counts as a mismatch and ends the run the normal way
	initial begin
		#200000;
		err_total++;
		results();
	end
endmodule
